// ---- design/mbar_pkg.sv ----
// constants and types shared by the barrier and write buffer logic
package mbar_pkg;
   localparam int ADDR_W     = 32;
   localparam int DATA_W     = 64;
   localparam int WB_DEPTH   = 4;
   localparam int IQ_DEPTH   = 4;
   localparam int PAGE_BITS  = 13;
   localparam int RST_STAGES = 2;

   typedef enum logic [2:0] {
      OP_LOAD     = 3'h0,
      OP_STORE    = 3'h1,
      OP_MBAR     = 3'h2,
      OP_IBAR     = 3'h3,
      OP_MAP_CHG  = 3'h4
   } op_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_DRAIN  = 3'h1,
      ST_IFLUSH = 3'h2,
      ST_VFLUSH = 3'h3
   } bar_state_t;
endpackage : mbar_pkg

// ---- design/wbuf_if.sv ----
// carrier between barrier logic and write buffer
`timescale 1ns/1ps
`default_nettype none
interface wbuf_if #(
   parameter int ADDR_W = mbar_pkg::ADDR_W,
   parameter int DATA_W = mbar_pkg::DATA_W
);
   logic              push_valid;
   logic              push_ready;
   logic [ADDR_W-1:0] push_addr;
   logic [DATA_W-1:0] push_data;
   logic [ADDR_W-1:0] look_paddr;
   logic [ADDR_W-1:0] look_vaddr;
   logic              fwd_hit;
   logic [DATA_W-1:0] fwd_data;
   logic              syn_hit;
   logic              empty;
   logic              mem_wr_valid;
   logic              mem_wr_commit;
   logic [ADDR_W-1:0] mem_wr_addr;
   logic [DATA_W-1:0] mem_wr_data;

   modport ctrl (output push_valid, push_addr, push_data, look_paddr, look_vaddr,
                 mem_wr_commit,
                 input  push_ready, fwd_hit, fwd_data, syn_hit, empty,
                 mem_wr_valid, mem_wr_addr, mem_wr_data);
   modport buffer (input  push_valid, push_addr, push_data, look_paddr, look_vaddr,
                   mem_wr_commit,
                   output push_ready, fwd_hit, fwd_data, syn_hit, empty,
                   mem_wr_valid, mem_wr_addr, mem_wr_data);
endinterface : wbuf_if
`default_nettype wire

// ---- design/write_buffer.sv ----
// in-order write buffer with forwarding and synonym match
`timescale 1ns/1ps
`default_nettype none
module write_buffer #(
   parameter int DEPTH     = mbar_pkg::WB_DEPTH,
   parameter int ADDR_W    = mbar_pkg::ADDR_W,
   parameter int DATA_W    = mbar_pkg::DATA_W,
   parameter int PAGE_BITS = mbar_pkg::PAGE_BITS
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // controller side
   wbuf_if.buffer    wb
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   // refused at elaboration, the pointers wrap by plain overflow
   if (DEPTH < 2 || (1 << PW) != DEPTH || PAGE_BITS >= ADDR_W) begin : g_bad_cfg
      $error("write_buffer: depth must be a power of two, page bits below addr width");
   end

   logic [ADDR_W-1:0] addr_q [DEPTH];
   logic [DATA_W-1:0] data_q [DEPTH];
   logic [PW-1:0]     head_q;
   logic [PW-1:0]     tail_q;
   logic [CW-1:0]     count_q;
   logic              push;
   logic              pop;

   assign wb.push_ready   = (count_q != CW'(DEPTH));                         // [R13]
   assign push            = wb.push_valid && wb.push_ready;
   // an entry leaves only once the subsystem has committed its order
   assign pop             = wb.mem_wr_valid && wb.mem_wr_commit;             // [R2] [R3]
   assign wb.empty        = (count_q == '0);                                 // [R13]
   assign wb.mem_wr_valid = !wb.empty;
   assign wb.mem_wr_addr  = addr_q[head_q];
   assign wb.mem_wr_data  = data_q[head_q];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         head_q  <= '0;
         tail_q  <= '0;
         count_q <= '0;
      end else begin
         if (push)
            tail_q <= tail_q + PW'(1);
         if (pop)
            head_q <= head_q + PW'(1);
         if (push && !pop)
            count_q <= count_q + CW'(1);
         else if (pop && !push)
            count_q <= count_q - CW'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         addr_q[tail_q] <= wb.push_addr;
         data_q[tail_q] <= wb.push_data;
      end
   end

   // youngest match wins so a hit never returns an older value
   always_comb begin
      logic [PW-1:0] idx;
      idx         = '0;
      wb.fwd_hit  = 1'b0;
      wb.fwd_data = '0;
      wb.syn_hit  = 1'b0;
      for (int k = 0; k < DEPTH; k++) begin
         idx = head_q + PW'(k);
         if (CW'(k) < count_q) begin
            if (addr_q[idx] == wb.look_paddr) begin                          // [R5]
               wb.fwd_hit  = 1'b1;
               wb.fwd_data = data_q[idx];
            end
            if (addr_q[idx][PAGE_BITS-1:0] == wb.look_vaddr[PAGE_BITS-1:0])
               wb.syn_hit = 1'b1;                                            // [R7]
         end
      end
   end

   AST_WB_FULL_REFUSES: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
      count_q == CW'(DEPTH) |-> !wb.push_ready)
      else $error("write buffer accepted while full");

   AST_WB_COMMIT_POPS: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
      pop && !push |=> count_q == $past(count_q) - CW'(1))
      else $error("committed write did not leave the buffer");
endmodule : write_buffer
`default_nettype wire

// ---- design/mem_barrier_unit.sv ----
// memory and istream barrier sequencing over write buffer and invalidate queue
// Functional notes
// R1 - ordering point per address is wherever the subsystem acknowledges the write commit
// R2 - either barrier completes only after all earlier writes reach their ordering point
// R3 - completion needs only committed write order, not the final storage write
// R4 - either barrier delivers all queued invalidates before any later access starts
// R5 - write buffer hits by physical address forward youngest data, never older values
// R6 - virtual cache data returns early only when no synonym write can be pending
// R7 - no write buffer match on untranslated bits proves no synonym write pending
// R8 - mapping changes make the virtual data cache flush affected state
// R9 - that flush may wait for the next barrier or translation_buffer fill
// R10 - peers write, barrier, interrupt; receiver barriers before touching shared data
// R11 - istream barrier makes the instruction cache coherent with memory
// R12 - later loads and stores stall while a barrier is outstanding
// R13 - write buffer and invalidate queue report empty so barrier avoids polling memory
`timescale 1ns/1ps
`default_nettype none
module mem_barrier_unit #(
   parameter int ADDR_W    = mbar_pkg::ADDR_W,
   parameter int DATA_W    = mbar_pkg::DATA_W,
   parameter int WB_DEPTH  = mbar_pkg::WB_DEPTH,
   parameter int IQ_DEPTH  = mbar_pkg::IQ_DEPTH,
   parameter int PAGE_BITS = mbar_pkg::PAGE_BITS
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   // pipeline issue
   input  wire logic              op_valid,
   output logic                   op_ready,
   input  wire mbar_pkg::op_t     op_code,
   input  wire logic [ADDR_W-1:0] op_vaddr,
   input  wire logic [ADDR_W-1:0] op_paddr,
   input  wire logic [DATA_W-1:0] op_wdata,
   // load result and barrier completion
   output logic                   load_done,
   output logic                   load_fwd,
   output logic [DATA_W-1:0]      load_fwd_data,
   output logic                   load_early_ok,
   output logic                   barrier_done,
   // coherent memory write port
   output logic                   mem_wr_valid,
   input  wire logic              mem_wr_commit,
   output logic [ADDR_W-1:0]      mem_wr_addr,
   output logic [DATA_W-1:0]      mem_wr_data,
   // incoming invalidates from the subsystem
   input  wire logic              inv_in_valid,
   output logic                   inv_in_ready,
   input  wire logic [ADDR_W-1:0] inv_in_addr,
   // invalidate delivery to the local data cache
   output logic                   dc_inv_valid,
   input  wire logic              dc_inv_ready,
   output logic [ADDR_W-1:0]      dc_inv_addr,
   // cache maintenance
   output logic                   icache_flush_req,
   input  wire logic              icache_flush_ack,
   output logic                   vcache_flush_req,
   input  wire logic              vcache_flush_ack,
   input  wire logic              translation_buffer_fill,
   output logic                   vcache_stale
);
   localparam int QW = $clog2(IQ_DEPTH);
   localparam int QC = $clog2(IQ_DEPTH + 1);

   if (IQ_DEPTH < 2 || (1 << QW) != IQ_DEPTH) begin : g_bad_cfg
      $error("mem_barrier_unit: invalidate queue depth must be a power of two");
   end

   // reset release through two flops; assert is asynchronous
   logic [mbar_pkg::RST_STAGES-1:0] rst_sync_q;
   logic                            rst_n;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         rst_sync_q <= '0;
      else
         rst_sync_q <= {rst_sync_q[mbar_pkg::RST_STAGES-2:0], 1'b1};
   end
   assign rst_n = rst_sync_q[mbar_pkg::RST_STAGES-1];

   wbuf_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) wb ();

   write_buffer #(
      .DEPTH     (WB_DEPTH),
      .ADDR_W    (ADDR_W),
      .DATA_W    (DATA_W),
      .PAGE_BITS (PAGE_BITS)
   ) write_buffer_inst (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .wb      (wb)
   );

   mbar_pkg::bar_state_t state_q;
   mbar_pkg::bar_state_t state_d;
   logic                 ibar_q;
   logic                 stale_q;
   logic                 accept;
   logic                 is_bar;
   logic                 drained;

   // invalidate queue
   logic [ADDR_W-1:0] iq_addr_q [IQ_DEPTH];
   logic [QW-1:0]     iq_head_q;
   logic [QW-1:0]     iq_tail_q;
   logic [QC-1:0]     iq_cnt_q;
   logic              iq_push;
   logic              iq_pop;

   assign inv_in_ready = (iq_cnt_q != QC'(IQ_DEPTH));
   assign iq_push      = inv_in_valid && inv_in_ready;
   assign dc_inv_valid = (iq_cnt_q != '0);
   assign dc_inv_addr  = iq_addr_q[iq_head_q];
   assign iq_pop       = dc_inv_valid && dc_inv_ready;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         iq_head_q <= '0;
         iq_tail_q <= '0;
         iq_cnt_q  <= '0;
      end else begin
         if (iq_push)
            iq_tail_q <= iq_tail_q + QW'(1);
         if (iq_pop)
            iq_head_q <= iq_head_q + QW'(1);
         if (iq_push && !iq_pop)
            iq_cnt_q <= iq_cnt_q + QC'(1);
         else if (iq_pop && !iq_push)
            iq_cnt_q <= iq_cnt_q - QC'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (iq_push)
         iq_addr_q[iq_tail_q] <= inv_in_addr;
   end

   // issue: anything after a barrier waits until the sequence ends
   assign is_bar   = (op_code == mbar_pkg::OP_MBAR) || (op_code == mbar_pkg::OP_IBAR);
   assign op_ready = (state_q == mbar_pkg::ST_IDLE) && !(translation_buffer_fill && stale_q)
                     && ((op_code != mbar_pkg::OP_STORE) || wb.push_ready);     // [R12]
   assign accept   = op_valid && op_ready;

   assign wb.push_valid   = accept && (op_code == mbar_pkg::OP_STORE);
   assign wb.push_addr    = op_paddr;
   assign wb.push_data    = op_wdata;
   assign wb.look_paddr   = op_paddr;
   assign wb.look_vaddr   = op_vaddr;
   // the commit ack marks the address's ordering point, wherever it currently lives
   assign wb.mem_wr_commit = mem_wr_commit;                                    // [R1]
   assign mem_wr_valid    = wb.mem_wr_valid;
   assign mem_wr_addr     = wb.mem_wr_addr;
   assign mem_wr_data     = wb.mem_wr_data;

   // both empties come straight from the queues, no memory polling
   assign drained = wb.empty && (iq_cnt_q == '0);                              // [R2] [R4] [R13]

   always_comb begin
      state_d = state_q;
      case (state_q)
         mbar_pkg::ST_IDLE: begin
            if (accept && is_bar)
               state_d = mbar_pkg::ST_DRAIN;
            else if (translation_buffer_fill && stale_q)
               state_d = mbar_pkg::ST_VFLUSH;                                  // [R9]
         end
         mbar_pkg::ST_DRAIN: begin
            if (drained) begin                                                 // [R2] [R4]
               if (ibar_q)
                  state_d = mbar_pkg::ST_IFLUSH;                               // [R11]
               else if (stale_q)
                  state_d = mbar_pkg::ST_VFLUSH;                               // [R9]
               else
                  state_d = mbar_pkg::ST_IDLE;
            end
         end
         mbar_pkg::ST_IFLUSH: begin
            if (icache_flush_ack)
               state_d = stale_q ? mbar_pkg::ST_VFLUSH : mbar_pkg::ST_IDLE;
         end
         mbar_pkg::ST_VFLUSH: begin
            if (vcache_flush_ack)
               state_d = mbar_pkg::ST_IDLE;
         end
         default: state_d = mbar_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= mbar_pkg::ST_IDLE;
         ibar_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         if (accept && is_bar)
            ibar_q <= (op_code == mbar_pkg::OP_IBAR);
      end
   end

   // completion pulse when a barrier sequence returns to idle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         barrier_done <= 1'b0;
      else
         barrier_done <= (state_q == mbar_pkg::ST_DRAIN || state_q == mbar_pkg::ST_IFLUSH
                          || state_q == mbar_pkg::ST_VFLUSH)
                         && (state_d == mbar_pkg::ST_IDLE);
   end

   // mapping change marks the virtual cache stale; flush is deferred, not skipped
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         stale_q <= 1'b0;
      else if (accept && op_code == mbar_pkg::OP_MAP_CHG)
         stale_q <= 1'b1;                                                      // [R8]
      else if (state_q == mbar_pkg::ST_VFLUSH && vcache_flush_ack)
         stale_q <= 1'b0;                                                      // [R8]
   end

   assign icache_flush_req = (state_q == mbar_pkg::ST_IFLUSH);                 // [R11]
   assign vcache_flush_req = (state_q == mbar_pkg::ST_VFLUSH);                 // [R8]
   assign vcache_stale     = stale_q;

   // load result: forwarding and early virtual return permission
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         load_done     <= 1'b0;
         load_fwd      <= 1'b0;
         load_fwd_data <= '0;
         load_early_ok <= 1'b0;
      end else begin
         load_done     <= accept && (op_code == mbar_pkg::OP_LOAD);
         load_fwd      <= accept && (op_code == mbar_pkg::OP_LOAD) && wb.fwd_hit;  // [R5]
         load_fwd_data <= wb.fwd_data;
         // conservative: a match on page-offset bits may be false, costing only latency
         load_early_ok <= accept && (op_code == mbar_pkg::OP_LOAD) && !wb.syn_hit; // [R6] [R7]
      end
   end

   AST_STALL_WHILE_BARRIER: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R12]
      state_q != mbar_pkg::ST_IDLE |-> !op_ready)
      else $error("issue accepted during barrier");

   AST_DRAIN_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
      state_q == mbar_pkg::ST_DRAIN && !wb.empty |=> state_q == mbar_pkg::ST_DRAIN)
      else $error("barrier left drain with writes pending");

   AST_INV_DELIVERED: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
      state_q == mbar_pkg::ST_DRAIN ##1 state_q != mbar_pkg::ST_DRAIN
      |-> $past(iq_cnt_q) == '0 && $past(wb.empty))
      else $error("barrier ended with invalidates queued");

   AST_IBAR_FLUSHES: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
      state_q == mbar_pkg::ST_DRAIN && drained && ibar_q
      |=> icache_flush_req)
      else $error("istream barrier skipped instruction cache flush");

   AST_DEFERRED_FLUSH: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
      state_q == mbar_pkg::ST_IDLE && translation_buffer_fill && stale_q && !op_valid
      |=> vcache_flush_req)
      else $error("fill with stale mapping did not flush virtual cache");

   AST_MAP_MARKS_STALE: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
      accept && op_code == mbar_pkg::OP_MAP_CHG |=> vcache_stale [*2])
      else $error("mapping change not recorded");

   AST_FORWARD_YOUNGEST: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
      accept && op_code == mbar_pkg::OP_LOAD && wb.fwd_hit
      |=> load_fwd && load_done && load_fwd_data == $past(wb.fwd_data))
      else $error("write buffer hit not forwarded");

   AST_NO_EARLY_ON_SYNONYM: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
      accept && op_code == mbar_pkg::OP_LOAD && wb.syn_hit |=> load_done && !load_early_ok)
      else $error("early virtual return despite synonym match");
endmodule : mem_barrier_unit
`default_nettype wire

// ---- sim/mem_partner.sv ----
// far-side model: write commit, invalidate source and cache acknowledgers
`timescale 1ns/1ps
`default_nettype none
module hs_responder (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       req,
   input  wire logic [3:0] stall,
   output logic            ack
);
   logic [3:0] cnt_q;
   // ack lasts one cycle so a held request is taken exactly once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         ack   <= 1'b0;
      end else if (req && !ack && cnt_q >= stall) begin
         ack <= 1'b1;
      end else begin
         ack   <= 1'b0;
         cnt_q <= (req && !ack) ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule : hs_responder

module mem_partner (
   // clock, reset and pacing
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic [3:0]  stall,
   // write port
   input  wire logic        mem_wr_valid,
   output logic             mem_wr_commit,
   input  wire logic [31:0] mem_wr_addr,
   input  wire logic [63:0] mem_wr_data,
   // invalidates
   output logic             inv_in_valid,
   input  wire logic        inv_in_ready,
   output logic [31:0]      inv_in_addr,
   input  wire logic        dc_inv_valid,
   output logic             dc_inv_ready,
   // cache maintenance
   input  wire logic        icache_flush_req,
   output logic             icache_flush_ack,
   input  wire logic        vcache_flush_req,
   output logic             vcache_flush_ack
);
   logic [31:0] log_addr[$];
   logic [63:0] log_data[$];
   int          n_dc = 0;
   hs_responder wr_inst (.clk(sys_clk), .rst_n(reset_n), .req(mem_wr_valid), .stall(stall),
      .ack(mem_wr_commit));
   hs_responder dc_inst (.clk(sys_clk), .rst_n(reset_n), .req(dc_inv_valid), .stall(stall),
      .ack(dc_inv_ready));
   hs_responder ic_inst (.clk(sys_clk), .rst_n(reset_n), .req(icache_flush_req),
      .stall(stall), .ack(icache_flush_ack));
   hs_responder vc_inst (.clk(sys_clk), .rst_n(reset_n), .req(vcache_flush_req),
      .stall(stall), .ack(vcache_flush_ack));
   // order is fixed at the acknowledge, not at some later storage write
   always @(posedge sys_clk) begin
      if (reset_n && mem_wr_valid && mem_wr_commit) begin
         log_addr.push_back(mem_wr_addr);
         log_data.push_back(mem_wr_data);
      end
      if (reset_n && dc_inv_valid && dc_inv_ready) n_dc++;
   end
   initial begin
      inv_in_valid = 1'b0;
      inv_in_addr  = 32'h0;
   end
   // a peer write shows up here as an invalidate
   // ok stays low when the bound runs out, so the bench can count it
   task automatic send_inv(input logic [31:0] a, output logic ok);
      int n;
      ok = 1'b0;
      @(posedge sys_clk);
      #1 inv_in_valid = 1'b1;
      inv_in_addr = a;
      for (n = 0; n < 50; n++) begin
         @(negedge sys_clk);
         if (inv_in_ready === 1'b1) begin
            ok = 1'b1;
            break;
         end
      end
      @(posedge sys_clk);
      #1 inv_in_valid = 1'b0;
      // released address shows garbage, not the last value
      inv_in_addr = ~a;
   endtask : send_inv
endmodule : mem_partner
`default_nettype wire

// ---- sim/memory_barrier_coherency_logic_test.sv ----
// self-checking bench for the barrier and write buffer logic
`timescale 1ns/1ps
`default_nettype none
module memory_barrier_coherency_logic_test;
   localparam logic [31:0] ADR_A = 32'h0004_1000;
   localparam logic [31:0] ADR_B = 32'h0004_2040;
   localparam logic [31:0] ADR_C = 32'h0004_2080;
   logic          sys_clk, reset_n, op_valid, op_ready, translation_buffer_fill;
   mbar_pkg::op_t op_code;
   logic [31:0]   op_vaddr, op_paddr, mem_wr_addr, inv_in_addr, dc_inv_addr;
   logic [63:0]   op_wdata, load_fwd_data, mem_wr_data;
   logic          load_done, load_fwd, load_early_ok, barrier_done, vcache_stale;
   logic          mem_wr_valid, mem_wr_commit, inv_in_valid, inv_in_ready;
   logic          dc_inv_valid, dc_inv_ready, icache_flush_req, icache_flush_ack;
   logic          vcache_flush_req, vcache_flush_ack, ic_seen, vc_seen;
   logic [3:0]    stall;
   int            n_tests, n_mismatch;

   mem_barrier_unit mem_barrier_unit_inst (.sys_clk(sys_clk), .reset_n(reset_n),
      .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_vaddr(op_vaddr),
      .op_paddr(op_paddr), .op_wdata(op_wdata), .load_done(load_done), .load_fwd(load_fwd),
      .load_fwd_data(load_fwd_data), .load_early_ok(load_early_ok),
      .barrier_done(barrier_done), .mem_wr_valid(mem_wr_valid),
      .mem_wr_commit(mem_wr_commit), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
      .inv_in_valid(inv_in_valid), .inv_in_ready(inv_in_ready), .inv_in_addr(inv_in_addr),
      .dc_inv_valid(dc_inv_valid), .dc_inv_ready(dc_inv_ready), .dc_inv_addr(dc_inv_addr),
      .icache_flush_req(icache_flush_req), .icache_flush_ack(icache_flush_ack),
      .vcache_flush_req(vcache_flush_req), .vcache_flush_ack(vcache_flush_ack),
      .translation_buffer_fill(translation_buffer_fill), .vcache_stale(vcache_stale));
   mem_partner mem_partner_inst (.sys_clk(sys_clk), .reset_n(reset_n), .stall(stall),
      .mem_wr_valid(mem_wr_valid), .mem_wr_commit(mem_wr_commit),
      .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .inv_in_valid(inv_in_valid),
      .inv_in_ready(inv_in_ready), .inv_in_addr(inv_in_addr), .dc_inv_valid(dc_inv_valid),
      .dc_inv_ready(dc_inv_ready), .icache_flush_req(icache_flush_req),
      .icache_flush_ack(icache_flush_ack), .vcache_flush_req(vcache_flush_req),
      .vcache_flush_ack(vcache_flush_ack));

   always #10 sys_clk = ~sys_clk;

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // a spent bound counts as a mismatch and ends the run
   task automatic timeout();
      chk(64'h1, 64'h0);
      close_out();
   endtask : timeout

   task automatic issue(input mbar_pkg::op_t c, input logic [31:0] va, input logic [31:0] pa,
                        input logic [63:0] wd);
      int n;
      @(posedge sys_clk);
      #1 op_valid = 1'b1;
      op_code  = c;
      op_vaddr = va;
      op_paddr = pa;
      op_wdata = wd;
      for (n = 0; n < 100; n++) begin
         @(negedge sys_clk);
         if (op_ready === 1'b1) break;
      end
      if (n == 100) timeout();
      @(posedge sys_clk);
      #1 op_valid = 1'b0;
   endtask : issue

   task automatic load_chk(input logic [31:0] va, input logic [31:0] pa, input logic fwd,
                           input logic [63:0] d, input logic early);
      issue(mbar_pkg::OP_LOAD, va, pa, 64'h0);
      @(negedge sys_clk);
      chk(64'(load_done), 64'h1);
      chk(64'(load_fwd), 64'(fwd));
      if (fwd) chk(load_fwd_data, d);
      chk(64'(load_early_ok), 64'(early));
   endtask : load_chk

   task automatic wait_done();
      int n;
      ic_seen = 1'b0;
      vc_seen = 1'b0;
      for (n = 0; n < 200; n++) begin
         @(negedge sys_clk);
         ic_seen = ic_seen | icache_flush_req;
         vc_seen = vc_seen | vcache_flush_req;
         if (barrier_done === 1'b1) break;
      end
      if (n == 200) timeout();
      chk(64'(mem_wr_valid), 64'h0);
      chk(64'(dc_inv_valid), 64'h0);
   endtask : wait_done

   task automatic s_forward_order();
      logic [31:0] ea[4];
      logic [63:0] ed[4];
      ea = '{ADR_A, ADR_A, ADR_B, ADR_C};
      ed = '{64'h11, 64'h22, 64'h33, 64'h44};
      stall = 4'hF;
      for (int i = 0; i < 4; i++) issue(mbar_pkg::OP_STORE, 32'h0, ea[i], ed[i]);
      // buffer is full, so a fifth store is held off
      @(posedge sys_clk);
      #1 op_valid = 1'b1;
      @(negedge sys_clk);
      chk(64'(op_ready), 64'h0);
      @(posedge sys_clk);
      #1 op_valid = 1'b0;
      load_chk(32'h0000_3000, ADR_A, 1'b1, 64'h22, 1'b0);
      load_chk(32'h0000_0100, 32'h0005_0000, 1'b0, 64'h0, 1'b1);
      issue(mbar_pkg::OP_MBAR, 32'h0, 32'h0, 64'h0);
      @(negedge sys_clk);
      chk(64'(op_ready), 64'h0);
      wait_done();
      chk(64'(mem_partner_inst.log_addr.size()), 64'h4);
      for (int i = 0; i < 4; i++) begin
         chk(64'(mem_partner_inst.log_addr[i]), 64'(ea[i]));
         chk(mem_partner_inst.log_data[i], ed[i]);
      end
      load_chk(32'h0000_3000, ADR_A, 1'b0, 64'h0, 1'b1);
   endtask : s_forward_order

   task automatic s_inval();
      logic ok;
      stall = 4'h6;
      mem_partner_inst.send_inv(32'h0000_8000, ok);
      if (ok !== 1'b1) timeout();
      // the slow acknowledger keeps the first entry at the head for a while
      @(negedge sys_clk);
      chk(64'(dc_inv_addr), 64'h8000);
      mem_partner_inst.send_inv(32'h0000_8040, ok);
      if (ok !== 1'b1) timeout();
      issue(mbar_pkg::OP_MBAR, 32'h0, 32'h0, 64'h0);
      wait_done();
      chk(64'(mem_partner_inst.n_dc), 64'h2);
   endtask : s_inval

   task automatic s_istream();
      stall = 4'h5;
      issue(mbar_pkg::OP_IBAR, 32'h0, 32'h0, 64'h0);
      wait_done();
      chk(64'(ic_seen), 64'h1);
      chk(64'(icache_flush_req), 64'h0);
   endtask : s_istream

   task automatic s_mapping();
      int n;
      stall = 4'h3;
      issue(mbar_pkg::OP_MAP_CHG, 32'h0, 32'h0, 64'h0);
      @(negedge sys_clk);
      chk(64'(vcache_stale), 64'h1);
      @(posedge sys_clk);
      #1 translation_buffer_fill = 1'b1;
      @(posedge sys_clk);
      #1 translation_buffer_fill = 1'b0;
      vc_seen = 1'b0;
      for (n = 0; n < 50 && vcache_stale !== 1'b0; n++) begin
         @(negedge sys_clk);
         vc_seen = vc_seen | vcache_flush_req;
      end
      if (n == 50) timeout();
      chk(64'(vc_seen), 64'h1);
      issue(mbar_pkg::OP_MAP_CHG, 32'h0, 32'h0, 64'h0);
      issue(mbar_pkg::OP_MBAR, 32'h0, 32'h0, 64'h0);
      wait_done();
      chk(64'(vc_seen), 64'h1);
      chk(64'(vcache_stale), 64'h0);
   endtask : s_mapping

   initial begin
      sys_clk = 1'b0;
      reset_n = 1'b0;
      op_valid = 1'b0;
      op_code = mbar_pkg::OP_LOAD;
      op_vaddr = 32'h0;
      op_paddr = 32'h0;
      op_wdata = 64'h0;
      translation_buffer_fill = 1'b0;
      stall = 4'h0;
      n_tests = 0;
      n_mismatch = 0;
      repeat (6) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      s_forward_order();
      s_inval();
      s_istream();
      s_mapping();
      close_out();
   end
endmodule : memory_barrier_coherency_logic_test
`default_nettype wire
